// File: logic/psc_pkg.sv
// Shared constants and types of the pedometer step counter
package psc_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned FUNC_RATE_HZ = 26;
  localparam int unsigned FUNC_TICK_CYC = CLK_HZ / FUNC_RATE_HZ;
  localparam int unsigned DEB_LSB_MS = 80;
  localparam int unsigned DEB_LSB_CYC = (CLK_HZ / 1000) * DEB_LSB_MS;
  localparam int unsigned DELTA_LSB_US = 1_638_400;
  localparam int unsigned DELTA_LSB_CYC = (CLK_HZ / 1_000_000) * DELTA_LSB_US;
  localparam int unsigned PIN_PULSE_NS = 150_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PIN_PULSE_CYC = PIN_PULSE_NS / CLK_PERIOD_NS;
  // Threshold weight in half-milli-g units: 32 mg and 62.5 mg
  localparam logic [6:0] THS_LSB_2G = 7'h40;
  localparam logic [6:0] THS_LSB_4G = 7'h7D;
  localparam int unsigned THS_DECAY_SHIFT = 3;
  localparam logic [4:0] GAP_MAX = 5'h1F;
  localparam logic [2:0] DEBOUNCE_STEPS_RST = 3'h6;
  localparam logic [4:0] DEBOUNCE_GAP_RST = 5'h0D;
  typedef logic [7:0] psc_byte_t;
  typedef logic [11:0] psc_thr_t;
  typedef enum logic [1:0] {
    PSC_IDLE = 2'h0,
    PSC_DEB = 2'h1,
    PSC_CNT = 2'h3
  } psc_mode_t;
endpackage

// File: logic/psc_pulse.sv
// Stretches a one-cycle event into a fixed-length pin pulse
`timescale 1ns/1ps
`default_nettype none
module psc_pulse #(
  parameter int unsigned CYCLES = 18750
) (
  input wire logic clk_sys,
  input wire logic srst,
  psc_pulse_if.drv port
);
  import psc_pkg::*;
  localparam int W = $clog2(CYCLES + 1);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic pulse;
  } psc_pulse_state_t;
  psc_pulse_state_t s_q, s_d;

  if (CYCLES < 1) begin : g_bad
    $error("psc_pulse needs a length of at least one cycle");
  end

  always_comb begin
    s_d = s_q;
    if (port.fire) begin
      s_d.cnt = W'(CYCLES - 1);
      s_d.pulse = 1'b1;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end else begin
      s_d.pulse = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.pulse = s_q.pulse;

  pulse_start_a: assert property (@(posedge clk_sys) disable iff (srst)
    port.fire |=> port.pulse) else $error("pulse did not start");
  pulse_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    port.pulse && s_q.cnt != '0 |=> port.pulse) else $error("pulse ended early");
endmodule
`default_nettype wire

// File: logic/psc_pulse_if.sv
// Request and answer of a pin pulse stretcher
`timescale 1ns/1ps
`default_nettype none
interface psc_pulse_if;
  logic fire;
  logic pulse;
  modport src (output fire, input pulse);
  modport drv (input fire, output pulse);
endinterface
`default_nettype wire

// File: logic/psc_tick.sv
// Restartable period tick generator
`timescale 1ns/1ps
`default_nettype none
module psc_tick #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic run,
  output logic tick
);
  import psc_pkg::*;
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } psc_tick_state_t;
  psc_tick_state_t s_q, s_d;

  if (CYCLES < 2) begin : g_bad
    $error("psc_tick needs at least two cycles per period");
  end

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == W'(CYCLES - 1)) begin
      s_d.cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  tick_single_a: assert property (@(posedge clk_sys) disable iff (srst)
    tick |=> !tick) else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// File: logic/psc_top.sv
// Pedometer step counter: debounce, count, timestamp, delta timer, interrupts
//
// How it works
// - Runs only with both enable bits set
// - Step count is 16 bits, two bytes
// - Count kept when off; cleared by clear bit
// - Clear bit not self-cleared; host writes 0
// - Debounce steps field sets first-increment minimum
// - Debounce plus one steps, then add all
// - Gap above debounce time restarts debounce
// - Unfinished debounce steps dropped after gap
// - Full scale 2 g, or 4 g selected
// - Minimum threshold weight 32 or 62.5 mg
// - Threshold decays toward minimum, never below
// - Step sets flag, routed to pin one
// - Delta timer fires when steps in window
// - Delta sets flag, routed to pin two
// - Overflow wraps count, signals pin two
// - Unlatched: short pin pulse, one-period flags
// - Latched routed events held until source read
// - Latched but unrouted flags still pulse
// - Step copies timestamp into stamp bytes
// - Stamp resolution follows high-resolution bit
`timescale 1ns/1ps
`default_nettype none
module psc_top #(
  parameter int unsigned FUNC_TICK_CYC = psc_pkg::FUNC_TICK_CYC,
  parameter int unsigned DEB_LSB_CYC = psc_pkg::DEB_LSB_CYC,
  parameter int unsigned DELTA_LSB_CYC = psc_pkg::DELTA_LSB_CYC,
  parameter int unsigned PIN_PULSE_CYC = psc_pkg::PIN_PULSE_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic step_strobe,
  input wire psc_pkg::psc_thr_t step_peak_level,
  input wire logic embedded_func_enable,
  input wire logic step_engine_enable,
  input wire logic step_count_clear,
  input wire logic [2:0] debounce_step_count,
  input wire logic [4:0] debounce_time,
  input wire logic step_full_scale_sel,
  input wire logic [4:0] step_min_threshold,
  input wire logic pin1_step_route,
  input wire logic pin2_delta_route,
  input wire logic pin2_overflow_route,
  input wire logic latch_irq_select,
  input wire logic timer_enable,
  input wire logic timer_high_resolution,
  input wire psc_pkg::psc_byte_t step_delta_period,
  input wire psc_pkg::psc_byte_t time_counter_upper,
  input wire psc_pkg::psc_byte_t time_counter_lower,
  input wire logic source_read,
  output psc_pkg::psc_byte_t step_count_high,
  output psc_pkg::psc_byte_t step_count_low,
  output psc_pkg::psc_byte_t step_stamp_high,
  output psc_pkg::psc_byte_t step_stamp_low,
  output logic step_stamp_fine,
  output logic step_detected_flag,
  output logic step_delta_flag,
  output logic step_overflow_flag,
  output logic irq_pin_one,
  output logic irq_pin_two,
  output psc_pkg::psc_thr_t step_threshold,
  output logic step_algo_4g
);
  import psc_pkg::*;

  typedef struct packed {
    psc_mode_t mode;
    logic [3:0] pend;
    logic [4:0] gap;
    logic [15:0] cnt;
    psc_byte_t win;
    logic seen;
    psc_byte_t stamp_hi;
    psc_byte_t stamp_lo;
    logic fine;
    logic fl_step;
    logic fl_delta;
    logic fl_ovf;
    logic pin1;
    logic pin2;
    psc_thr_t thr;
    logic fs4;
  } psc_top_state_t;

  psc_top_state_t s_q, s_d;

  if (FUNC_TICK_CYC < 2 || DEB_LSB_CYC < 2 || DELTA_LSB_CYC < 2 || PIN_PULSE_CYC < 1) begin : g_bad
    $error("psc_top timing counts too small");
  end

  // Next value of an interrupt flag; a new event wins over any clear
  function automatic logic flag_next(input logic cur, input logic evt, input logic held,
                                     input logic rd, input logic tick);
    logic r;
    r = cur;
    if (evt) begin
      r = 1'b1;
    end else if (held) begin
      r = cur & ~rd;
    end else if (tick) begin
      r = 1'b0;
    end
    return r;
  endfunction

  logic active;
  logic step;
  logic delta_on;
  logic tick26;
  logic tick80;
  logic tick_delta;
  logic stale;
  logic step_evt;
  logic delta_evt;
  logic ovf_evt;
  logic [3:0] add;
  logic [3:0] newp;
  logic [16:0] sum;
  logic [6:0] ths_lsb;
  psc_thr_t floor_w;
  psc_thr_t decay;
  logic held_step;
  logic held_delta;
  logic held_ovf;

  psc_pulse_if p1 ();
  psc_pulse_if p2 ();

  assign active = embedded_func_enable & step_engine_enable;
  assign step = step_strobe & active;
  assign delta_on = active & timer_enable & ~timer_high_resolution
                    & (step_delta_period != 8'h00);
  assign ths_lsb = step_full_scale_sel ? THS_LSB_4G : THS_LSB_2G;
  assign floor_w = psc_thr_t'(step_min_threshold) * psc_thr_t'(ths_lsb);
  assign held_step = latch_irq_select & pin1_step_route;
  assign held_delta = latch_irq_select & pin2_delta_route;
  assign held_ovf = latch_irq_select & pin2_overflow_route;

  psc_tick #(.CYCLES(FUNC_TICK_CYC)) u_tick26 (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(1'b1),
    .tick(tick26)
  );

  // Gap timer restarts on every step
  psc_tick #(.CYCLES(DEB_LSB_CYC)) u_tick80 (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(active & ~step),
    .tick(tick80)
  );

  psc_tick #(.CYCLES(DELTA_LSB_CYC)) u_tick_delta (
    .clk_sys(clk_sys),
    .srst(srst),
    .run(delta_on),
    .tick(tick_delta)
  );

  psc_pulse #(.CYCLES(PIN_PULSE_CYC)) u_pulse1 (
    .clk_sys(clk_sys),
    .srst(srst),
    .port(p1)
  );

  psc_pulse #(.CYCLES(PIN_PULSE_CYC)) u_pulse2 (
    .clk_sys(clk_sys),
    .srst(srst),
    .port(p2)
  );

  always_comb begin
    s_d = s_q;
    add = 4'h0;
    newp = 4'h0;
    sum = 17'h00000;
    decay = '0;
    step_evt = 1'b0;
    delta_evt = 1'b0;
    ovf_evt = 1'b0;
    stale = (s_q.gap > debounce_time);
    s_d.fs4 = step_full_scale_sel;
    s_d.fine = timer_high_resolution;

    // Debounce and step counting
    if (!active) begin
      s_d.mode = PSC_IDLE;
      s_d.pend = 4'h0;
      s_d.gap = 5'h00;
    end else begin
      if (s_q.mode == PSC_IDLE || stale) begin
        s_d.mode = PSC_DEB;
        s_d.pend = 4'h0;
      end
      if (step) begin
        s_d.gap = 5'h00;
        s_d.stamp_hi = time_counter_upper;
        s_d.stamp_lo = time_counter_lower;
        case (s_d.mode)
          PSC_CNT: begin
            add = 4'h1;
            step_evt = 1'b1;
          end
          default: begin
            newp = s_d.pend + 4'h1;
            if (newp > {1'b0, debounce_step_count}) begin
              add = newp;
              s_d.pend = 4'h0;
              s_d.mode = PSC_CNT;
              step_evt = 1'b1;
            end else begin
              s_d.pend = newp;
            end
          end
        endcase
      end else if (tick80 && s_q.gap != GAP_MAX) begin
        s_d.gap = s_q.gap + 5'h01;
      end
    end

    if (step_count_clear) begin
      s_d.cnt = 16'h0000;
    end else if (add != 4'h0) begin
      sum = {1'b0, s_q.cnt} + {13'h0000, add};
      s_d.cnt = sum[15:0];
      ovf_evt = sum[16];
    end

    // Step-delta window
    if (!delta_on) begin
      s_d.win = 8'h00;
      s_d.seen = 1'b0;
    end else begin
      if (step) begin
        s_d.seen = 1'b1;
      end
      if (tick_delta) begin
        if (s_q.win + 8'h01 >= step_delta_period) begin
          s_d.win = 8'h00;
          delta_evt = s_q.seen | step;
          s_d.seen = 1'b0;
        end else begin
          s_d.win = s_q.win + 8'h01;
        end
      end
    end

    // Adaptive threshold floor
    if (step) begin
      s_d.thr = (step_peak_level > floor_w) ? step_peak_level : floor_w;
    end else if (s_q.thr < floor_w) begin
      s_d.thr = floor_w;
    end else if (tick26 && s_q.thr > floor_w) begin
      decay = (s_q.thr - floor_w) >> THS_DECAY_SHIFT;
      s_d.thr = s_q.thr - ((decay == '0) ? psc_thr_t'(1) : decay);
    end

    s_d.fl_step = flag_next(s_q.fl_step, step_evt, held_step, source_read,
                            tick26);
    s_d.fl_delta = flag_next(s_q.fl_delta, delta_evt, held_delta, source_read,
                             tick26);
    s_d.fl_ovf = flag_next(s_q.fl_ovf, ovf_evt, held_ovf, source_read,
                           tick26);

    if (latch_irq_select) begin
      s_d.pin1 = s_d.fl_step & pin1_step_route;
      s_d.pin2 = (s_d.fl_delta & pin2_delta_route) | (s_d.fl_ovf & pin2_overflow_route);
    end else begin
      s_d.pin1 = p1.pulse;
      s_d.pin2 = p2.pulse;
    end
  end

  assign p1.fire = step_evt & pin1_step_route & ~latch_irq_select;
  assign p2.fire = ((delta_evt & pin2_delta_route) | (ovf_evt & pin2_overflow_route))
                   & ~latch_irq_select;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign step_count_high = s_q.cnt[15:8];
  assign step_count_low = s_q.cnt[7:0];
  assign step_stamp_high = s_q.stamp_hi;
  assign step_stamp_low = s_q.stamp_lo;
  assign step_stamp_fine = s_q.fine;
  assign step_detected_flag = s_q.fl_step;
  assign step_delta_flag = s_q.fl_delta;
  assign step_overflow_flag = s_q.fl_ovf;
  assign irq_pin_one = s_q.pin1;
  assign irq_pin_two = s_q.pin2;
  assign step_threshold = s_q.thr;
  assign step_algo_4g = s_q.fs4;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  count_clear_a: assert property (step_count_clear |=> s_q.cnt == 16'h0000)
    else $error("count not cleared");
  clear_held_a: assert property (step_count_clear ##1 step_count_clear |-> s_q.cnt == 16'h0000)
    else $error("count moved while clear held");
  count_kept_a: assert property (!active && !step_count_clear |=> $stable(s_q.cnt))
    else $error("count changed while disabled");
  first_incr_a: assert property (active && step_strobe && !step_count_clear
      && s_q.mode == PSC_DEB && !stale && s_q.pend == {1'b0, debounce_step_count}
      |=> s_q.cnt == $past(s_q.cnt) + 16'($past(debounce_step_count)) + 16'h0001
      && s_q.mode == PSC_CNT)
    else $error("pending steps not added at debounce");
  deb_restart_a: assert property (active && s_q.mode == PSC_CNT && stale && !step_strobe
      |=> s_q.mode == PSC_DEB && s_q.pend == 4'h0)
    else $error("debounce did not restart");
  ovf_wrap_a: assert property (active && step_strobe && !step_count_clear
      && s_q.mode == PSC_CNT && !stale && s_q.cnt == 16'hFFFF && pin2_overflow_route
      && $stable(pin2_overflow_route)
      |=> s_q.cnt == 16'h0000 && s_q.fl_ovf ##[0:2] irq_pin_two)
    else $error("overflow not wrapped or signalled");
  latch_hold_a: assert property (held_step && s_q.fl_step && !source_read
      |=> s_q.fl_step)
    else $error("latched step flag dropped");
  read_clear_a: assert property (held_step && s_q.fl_step && source_read && !step_strobe
      |=> !s_q.fl_step)
    else $error("source read did not clear flag");
  flag_pulse_a: assert property (!held_step && s_q.fl_step && tick26 && !step_strobe
      |=> !s_q.fl_step)
    else $error("unlatched flag outlived its period");
  stamp_copy_a: assert property (step |=> s_q.stamp_hi == $past(time_counter_upper)
      && s_q.stamp_lo == $past(time_counter_lower))
    else $error("timestamp not captured");
  thr_floor_a: assert property (!$past(srst) |-> s_q.thr >= $past(floor_w))
    else $error("threshold below minimum");
  delta_off_a: assert property (!delta_on |=> s_q.win == 8'h00 && !s_q.seen)
    else $error("delta window ran while disabled");

  first_count_c: cover property (s_q.mode == PSC_DEB ##1 s_q.mode == PSC_CNT);
  overflow_c: cover property (s_q.fl_ovf && irq_pin_two);
  delta_c: cover property (s_q.fl_delta);
  latched_read_c: cover property (held_step && s_q.fl_step && source_read);
endmodule
`default_nettype wire

// File: verification/psc_host_model.sv
// Step source and host read model facing the pedometer
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
  input wire logic clk_sys,
  output logic step_strobe,
  output psc_pkg::psc_thr_t step_peak_level,
  output logic source_read
);
  import psc_pkg::*;
  initial begin
    step_strobe = 1'b0;
    step_peak_level = 12'h000;
    source_read = 1'b0;
  end
  // Strobe held n cycles, one step per cycle
  task automatic steps(input int n, input psc_thr_t pk);
    @(negedge clk_sys);
    step_strobe = 1'b1;
    step_peak_level = pk;
    repeat (n) @(negedge clk_sys);
    step_strobe = 1'b0;
    step_peak_level = ~pk;
  endtask
  task automatic read_source();
    @(negedge clk_sys);
    source_read = 1'b1;
    @(negedge clk_sys);
    source_read = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verification/psc_top_tb_top.sv
// Self-checking bench of the pedometer step counter
`timescale 1ns/1ps
`default_nettype none
module psc_top_tb_top;
  import psc_pkg::*;
  localparam int TICK = 20;
  localparam int DEB = 10;
  localparam int PULSE = 4;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic step_strobe, source_read;
  psc_thr_t step_peak_level, step_threshold;
  logic embedded_func_enable = 1'b0, step_engine_enable = 1'b0, step_count_clear = 1'b0;
  logic [2:0] debounce_step_count = DEBOUNCE_STEPS_RST;
  logic [4:0] debounce_time = DEBOUNCE_GAP_RST, step_min_threshold = 5'h00;
  logic step_full_scale_sel = 1'b0, pin1_step_route = 1'b0, pin2_delta_route = 1'b0;
  logic pin2_overflow_route = 1'b0, latch_irq_select = 1'b0, timer_enable = 1'b0;
  logic timer_high_resolution = 1'b0;
  psc_byte_t step_delta_period = 8'h00, time_counter_upper = 8'h00, time_counter_lower = 8'h00;
  psc_byte_t step_count_high, step_count_low, step_stamp_high, step_stamp_low;
  logic step_stamp_fine, step_detected_flag, step_delta_flag, step_overflow_flag;
  logic irq_pin_one, irq_pin_two, step_algo_4g;
  int n_errors = 0, total_checks = 0, cyc = 0, cnt = 0, pend = 0, i, k;
  bit counting = 1'b0;
  logic [31:0] seed = 32'h8BF7;
  logic [15:0] exp_stamp = 16'h0000;
  logic [11:0] floor_v;
  logic [1:0] seen;

  always #4 clk_sys = ~clk_sys;

  psc_host_model host (.clk_sys(clk_sys), .step_strobe(step_strobe),
    .step_peak_level(step_peak_level), .source_read(source_read));

  psc_top #(.FUNC_TICK_CYC(TICK), .DEB_LSB_CYC(DEB), .DELTA_LSB_CYC(10),
    .PIN_PULSE_CYC(PULSE)) i_dut (
    .clk_sys(clk_sys), .srst(srst), .step_strobe(step_strobe),
    .step_peak_level(step_peak_level), .embedded_func_enable(embedded_func_enable),
    .step_engine_enable(step_engine_enable), .step_count_clear(step_count_clear),
    .debounce_step_count(debounce_step_count), .debounce_time(debounce_time),
    .step_full_scale_sel(step_full_scale_sel), .step_min_threshold(step_min_threshold),
    .pin1_step_route(pin1_step_route), .pin2_delta_route(pin2_delta_route),
    .pin2_overflow_route(pin2_overflow_route), .latch_irq_select(latch_irq_select),
    .timer_enable(timer_enable), .timer_high_resolution(timer_high_resolution),
    .step_delta_period(step_delta_period), .time_counter_upper(time_counter_upper),
    .time_counter_lower(time_counter_lower), .source_read(source_read),
    .step_count_high(step_count_high), .step_count_low(step_count_low),
    .step_stamp_high(step_stamp_high), .step_stamp_low(step_stamp_low),
    .step_stamp_fine(step_stamp_fine), .step_detected_flag(step_detected_flag),
    .step_delta_flag(step_delta_flag), .step_overflow_flag(step_overflow_flag),
    .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two),
    .step_threshold(step_threshold), .step_algo_4g(step_algo_4g));

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // Reference count: pending steps until debounce met, then every step
  task automatic model_step();
    if (counting) cnt = (cnt + 1) % 65536;
    else begin
      pend++;
      if (pend > int'(debounce_step_count)) begin
        cnt = (cnt + pend) % 65536;
        counting = 1'b1;
      end
    end
  endtask

  task automatic gap();
    repeat ((int'(debounce_time) + 3) * DEB) @(negedge clk_sys);
    counting = 1'b0;
    pend = 0;
  endtask

  task automatic step(input bit on, input psc_thr_t pk);
    logic [15:0] ts;
    seed = xs(seed);
    ts = seed[15:0];
    {time_counter_upper, time_counter_lower} = ts;
    host.steps(1, pk);
    @(negedge clk_sys);
    if (on) begin
      model_step();
      exp_stamp = ts;
    end
    chk({step_count_high, step_count_low}, 16'(cnt));
    if (on) chk({step_stamp_high, step_stamp_low}, exp_stamp);
  endtask

  task automatic watch(input int n);
    seen = 2'b00;
    repeat (n) begin
      @(negedge clk_sys);
      seen = seen | {step_delta_flag, irq_pin_two};
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    chk({step_count_high, step_count_low}, 16'h0000);
    chk(16'(step_detected_flag), 16'h0000);
    embedded_func_enable = 1'b1;
    repeat (3) step(1'b0, 12'h100);
    step_engine_enable = 1'b1;
    pin1_step_route = 1'b1;
    for (i = 0; i < 8; i++) begin
      step(1'b1, 12'h200);
      chk(step_detected_flag, 16'(i >= 6));
    end
    @(negedge clk_sys);
    chk(irq_pin_one, 16'h0001);
    repeat (TICK + 2) @(negedge clk_sys);
    chk({irq_pin_one, step_detected_flag}, 16'h0000);
    gap();
    repeat (2) step(1'b1, 12'h200);
    gap();
    repeat (7) step(1'b1, 12'h200);
    latch_irq_select = 1'b1;
    step(1'b1, 12'h200);
    repeat (3 * TICK) @(negedge clk_sys);
    chk({step_detected_flag, irq_pin_one}, 16'h0003);
    host.read_source();
    @(negedge clk_sys);
    chk({step_detected_flag, irq_pin_one}, 16'h0000);
    pin1_step_route = 1'b0;
    step(1'b1, 12'h200);
    repeat (TICK + 2) @(negedge clk_sys);
    chk(step_detected_flag, 16'h0000);
    latch_irq_select = 1'b0;
    step_engine_enable = 1'b0;
    repeat (2) step(1'b0, 12'h200);
    step_engine_enable = 1'b1;
    counting = 1'b0;
    pend = 0;
    debounce_step_count = 3'h0;
    step_count_clear = 1'b1;
    cnt = 0;
    repeat (2) @(negedge clk_sys);
    step(1'b0, 12'h200);
    step_count_clear = 1'b0;
    pin2_overflow_route = 1'b1;
    host.steps(65535, 12'h200);
    @(negedge clk_sys);
    repeat (65535) model_step();
    chk({step_count_high, step_count_low}, 16'(cnt));
    step(1'b1, 12'h200);
    chk(step_overflow_flag, 16'h0001);
    @(negedge clk_sys);
    chk(irq_pin_two, 16'h0001);
    pin2_overflow_route = 1'b0;
    repeat (TICK) @(negedge clk_sys);
    timer_enable = 1'b1;
    pin2_delta_route = 1'b1;
    step(1'b1, 12'h200);
    watch(80);
    chk(seen, 16'h0000);
    step_delta_period = 8'h02;
    step(1'b1, 12'h200);
    watch(80);
    chk(seen, 16'h0003);
    timer_high_resolution = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(step_stamp_fine, 16'h0001);
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      step_full_scale_sel = seed[5];
      step_min_threshold = seed[4:0];
      floor_v = 12'(seed[4:0]) * (seed[5] ? 12'(THS_LSB_4G) : 12'(THS_LSB_2G));
      step(1'b1, 12'hFFF);
      for (k = 0; k < 2000; k++) begin
        @(negedge clk_sys);
        chk(16'(step_threshold >= floor_v), 16'h0001);
      end
      chk(step_threshold, floor_v);
      chk(step_algo_4g, step_full_scale_sel);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
